/* File: inc/lip_pkg.sv */
// Constants, functions and behaviour summary for the local interrupt prioritizer
// Behaviour
// - One non-maskable, six local and six system-bus requests merge into a single prioritized request.
// - A polled mode lets software read pending requests without the processor being interrupted.
// - Software programs per local request whether it is enabled and whether it is edge or level.
// - Status shows local and bus pending, the poll level and the level acknowledged most recently.
// - The test switch raises a non-maskable request at level 7.
// - The two parallel timer units request on levels 6 and 5.
// - The dual serial controller requests on level 4.
// - The multi-function peripheral requests on level 3.
// - The network controller requests on level 2.
// - The disk-interface controller requests on level 1.
// - Each 24-bit timer interrupts through its parallel timer unit's request line.
// - The system-bus failure lines are passed to the first parallel timer unit for monitoring.
package lip_pkg;
	localparam int LIP_LEVELS = 8;
	localparam logic [2:0] LIP_LVL_NMI = 3'h7;
	localparam logic [2:0] LIP_LVL_PTU1 = 3'h6;
	localparam logic [2:0] LIP_LVL_PTU2 = 3'h5;
	localparam logic [2:0] LIP_LVL_SERIAL = 3'h4;
	localparam logic [2:0] LIP_LVL_MULTI = 3'h3;
	localparam logic [2:0] LIP_LVL_NET = 3'h2;
	localparam logic [2:0] LIP_LVL_DISK = 3'h1;
	localparam logic [7:0] LIP_ENABLE_RESET = 8'h00;
	localparam logic [7:0] LIP_EDGE_RESET = 8'h00;
	localparam logic [2:0] LIP_ACK_RESET = 3'h0;
	localparam logic [6:0] LIP_SYS_MASK_RESET = 7'h00;

	// Highest set bit index of an 8-bit vector, 0 when none
	function automatic logic [2:0] lip_top_level(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// True when the acknowledge strobe names the given level
	function automatic logic lip_hit(input logic a, input logic [2:0] al, input logic [2:0] lvl);
		return a && (al == lvl);
	endfunction
endpackage

/* File: core/lip_capture.sv */
// Per-level request capture with edge/level mode and acknowledge clear
`timescale 1ns/1ns
`default_nettype none
module lip_capture
	import lip_pkg::*;
(
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Request and programming
	input wire logic req,
	input wire logic enable,
	input wire logic edge_mode,
	input wire logic ack,
	// Result
	output logic pending
);
	logic prev;
	logic latch;
	wire rise = req & ~prev;

	// Edge requests latch; a new edge in the ack cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			prev <= 1'b0;
			latch <= 1'b0;
		end else if (ce) begin
			prev <= req;
			latch <= enable & (rise | (latch & ~ack));
		end
	end

	// Level requests follow the source, so withdrawal clears them
	assign pending = enable & (edge_mode ? latch : req);
endmodule
`default_nettype wire

/* File: core/lip_top.sv */
// Local interrupt prioritizer top level
`timescale 1ns/1ns
`default_nettype none
module lip_top
	import lip_pkg::*;
(
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Local sources
	input wire logic test_switch,
	input wire logic ptu1_req,
	input wire logic ptu1_timer_req,
	input wire logic ptu2_req,
	input wire logic ptu2_timer_req,
	input wire logic dual_serial_controller_req,
	input wire logic multi_function_peripheral_req,
	input wire logic network_req,
	input wire logic disk_req,
	// System bus
	input wire logic [6:1] sysbus_irq,
	input wire logic sysfail_n,
	input wire logic acfail_n,
	// Programming from software
	input wire logic [7:1] local_enable,
	input wire logic [7:1] local_edge,
	input wire logic [6:1] sys_enable,
	input wire logic poll_mode,
	// Processor acknowledge
	input wire logic ack,
	input wire logic [2:0] ack_level,
	// Processor request and status
	output logic [2:0] cpu_ipl,
	output logic cpu_nmi,
	output logic [7:1] local_pending,
	output logic [6:1] sys_pending,
	output logic [2:0] last_ack,
	output logic ack_valid,
	output logic [2:0] poll_level,
	// Failure lines to first parallel timer unit
	output logic first_parallel_timer_unit_sysfail,
	output logic first_parallel_timer_unit_acfail
);
	wire [7:1] raw_local;
	wire [7:1] pend_local;
	wire [7:0] merged;
	wire [2:0] best;
	wire [7:1] ack_hit;
	logic sw_prev;
	logic nmi_latch;

	// Fixed source to level map; timers share their unit's line
	assign raw_local[LIP_LVL_PTU1] = ptu1_req | ptu1_timer_req;
	assign raw_local[LIP_LVL_PTU2] = ptu2_req | ptu2_timer_req;
	assign raw_local[LIP_LVL_SERIAL] = dual_serial_controller_req;
	assign raw_local[LIP_LVL_MULTI] = multi_function_peripheral_req;
	assign raw_local[LIP_LVL_NET] = network_req;
	assign raw_local[LIP_LVL_DISK] = disk_req;
	assign raw_local[LIP_LVL_NMI] = 1'b0;

	// Acknowledge decode per level, shared by all captures
	for (genvar h = 1; h < 8; h++) begin : g_hit
		assign ack_hit[h] = lip_hit(ack, ack_level, 3'(h));
	end

	// Capture for levels 1..6
	for (genvar g = 1; g < 7; g++) begin : g_cap
		lip_capture u_cap (
			.clk(clk),
			.reset(reset),
			.ce(ce),
			.req(raw_local[g]),
			.enable(local_enable[g]),
			.edge_mode(local_edge[g]),
			.ack(ack_hit[g]),
			.pending(pend_local[g])
		);
	end

	// Non-maskable switch: always edge latched, ignores enable
	always_ff @(posedge clk) begin
		if (reset) begin
			sw_prev <= 1'b0;
			nmi_latch <= 1'b0;
		end else if (ce) begin
			sw_prev <= test_switch;
			nmi_latch <= (test_switch & ~sw_prev) | (nmi_latch & ~ack_hit[LIP_LVL_NMI]);
		end
	end
	assign pend_local[LIP_LVL_NMI] = nmi_latch;

	// Merge local and bus requests; level 7 always top
	assign merged = {pend_local[7], pend_local[6:1] | (sysbus_irq & sys_enable), 1'b0};
	assign best = lip_top_level(merged);

	// Registered outputs; poll mode keeps the processor line quiet
	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_ipl <= 3'h0;
			cpu_nmi <= 1'b0;
			local_pending <= 7'h00;
			sys_pending <= 6'h00;
			poll_level <= 3'h0;
			first_parallel_timer_unit_sysfail <= 1'b0;
			first_parallel_timer_unit_acfail <= 1'b0;
		end else if (ce) begin
			cpu_ipl <= poll_mode ? 3'h0 : best;
			cpu_nmi <= ~poll_mode & merged[7];
			local_pending <= pend_local;
			sys_pending <= sysbus_irq & sys_enable;
			poll_level <= best;
			first_parallel_timer_unit_sysfail <= ~sysfail_n;
			first_parallel_timer_unit_acfail <= ~acfail_n;
		end
	end

	// Last acknowledged level kept for status
	always_ff @(posedge clk) begin
		if (reset) begin
			last_ack <= LIP_ACK_RESET;
			ack_valid <= 1'b0;
		end else if (ce && ack) begin
			last_ack <= ack_level;
			ack_valid <= 1'b1;
		end
	end

	// Named steps: a switch edge seen, then one running cycle to show it
	sequence s_nmi_armed;
		(ce && test_switch && !sw_prev) ##1 (ce && !poll_mode);
	endsequence

	// An accepted acknowledge strobe
	sequence s_ack_step;
		ce && ack;
	endsequence

	// Ordering of the presented level
	a_nmi_top: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && nmi_latch |=> cpu_ipl == 3'h7)
		else $error("nmi not on top");

	a_nmi_raise: assert property (@(posedge clk) disable iff (reset)
		s_nmi_armed |=> cpu_nmi && cpu_ipl == LIP_LVL_NMI)
		else $error("switch edge did not raise nmi");

	a_none_idle: assert property (@(posedge clk) disable iff (reset)
		ce && merged == 8'h00 |=> cpu_ipl == 3'h0 && poll_level == 3'h0 && !cpu_nmi)
		else $error("level shown with nothing pending");

	// Polled operation keeps the processor lines quiet
	a_poll_quiet: assert property (@(posedge clk) disable iff (reset)
		ce && poll_mode |=> cpu_ipl == 3'h0)
		else $error("poll mode drove cpu");

	a_poll_nmi: assert property (@(posedge clk) disable iff (reset)
		ce && poll_mode |=> !cpu_nmi)
		else $error("poll mode drove nmi");

	a_poll_level: assert property (@(posedge clk) disable iff (reset)
		ce |=> poll_level == $past(best))
		else $error("poll level stale");

	// Acknowledge record and status
	a_ack_record: assert property (@(posedge clk) disable iff (reset)
		ce && ack |=> last_ack == $past(ack_level))
		else $error("ack not recorded");

	a_ack_valid: assert property (@(posedge clk) disable iff (reset)
		s_ack_step |=> ack_valid)
		else $error("ack valid not set");

	a_valid_sticky: assert property (@(posedge clk) disable iff (reset)
		ack_valid |=> ack_valid)
		else $error("ack valid dropped");

	a_sys_status: assert property (@(posedge clk) disable iff (reset)
		ce |=> sys_pending == $past(sysbus_irq & sys_enable))
		else $error("bus pending status wrong");

	// Frozen clock enable holds cpu_ipl, local_pending and last_ack
	a_ce_freeze: assert property (@(posedge clk) disable iff (reset)
		!ce |=> $stable(cpu_ipl) && $stable(local_pending) && $stable(last_ack))
		else $error("state moved with enable low");

	// Failure lines reach the first parallel timer unit
	a_fail_route: assert property (@(posedge clk) disable iff (reset)
		ce |=> first_parallel_timer_unit_acfail == !$past(acfail_n))
		else $error("acfail not routed");

	a_sysfail_route: assert property (@(posedge clk) disable iff (reset)
		ce |=> first_parallel_timer_unit_sysfail == !$past(sysfail_n))
		else $error("sysfail not routed");

	// Fixed source levels, each checked alone at the top
	a_ptu1_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && local_enable[6] && !local_edge[6] && ptu1_timer_req && !merged[7]
		|=> cpu_ipl == LIP_LVL_PTU1)
		else $error("first unit timer level wrong");

	a_ptu2_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && local_enable[5] && !local_edge[5] && ptu2_timer_req && merged[7:6] == 2'h0
		|=> cpu_ipl == LIP_LVL_PTU2)
		else $error("second unit timer level wrong");

	a_serial_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && local_enable[4] && !local_edge[4] && dual_serial_controller_req && merged[7:5] == 3'h0
		|=> cpu_ipl == 3'h4)
		else $error("serial level wrong");

	a_multi_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && local_enable[3] && !local_edge[3] && multi_function_peripheral_req
		&& merged[7:4] == 4'h0 |=> cpu_ipl == LIP_LVL_MULTI)
		else $error("peripheral level wrong");

	a_net_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && local_enable[2] && !local_edge[2] && network_req && merged[7:3] == 5'h00
		|=> cpu_ipl == LIP_LVL_NET)
		else $error("network level wrong");

	a_disk_lvl: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && pend_local == 7'h01 && (sysbus_irq & sys_enable) == 6'h00
		|=> cpu_ipl == LIP_LVL_DISK)
		else $error("disk level wrong");

	a_bus_level: assert property (@(posedge clk) disable iff (reset)
		ce && !poll_mode && sysbus_irq[4] && sys_enable[4] && merged[7:5] == 3'h0
		|=> cpu_ipl == 3'h4)
		else $error("bus request level wrong");

	// Pending life of level and edge requests
	a_level_drop: assert property (@(posedge clk) disable iff (reset)
		ce && local_enable[2] && !local_edge[2] && !network_req |=> !local_pending[2])
		else $error("withdrawn level stayed pending");

	a_edge_hold: assert property (@(posedge clk) disable iff (reset)
		ce && local_enable[1] && local_edge[1] && pend_local[1] && !ack_hit[1]
		|=> pend_local[1] || !local_enable[1] || !local_edge[1])
		else $error("edge request lost before ack");
endmodule
`default_nettype wire

/* File: dv/lip_cpu_model.sv */
// Processor-side model that acknowledges the presented level
`timescale 1ns/1ns
`default_nettype none
module lip_cpu_model (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic [3:0] lag,
	// Prioritizer side
	input wire logic [2:0] cpu_ipl,
	output logic ack,
	output logic [2:0] ack_level
);
	logic [3:0] cnt;
	// Level lines flip when idle so a stale value never looks valid
	always_ff @(posedge clk) begin
		ack <= 1'b0;
		ack_level <= reset ? 3'h0 : ~ack_level;
		if (reset || !run || cpu_ipl == 3'h0) begin
			cnt <= 4'h0;
		end else if (cnt == lag) begin
			ack <= 1'b1;
			ack_level <= cpu_ipl;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: dv/local_interrupt_prioritizer_test.sv */
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ns
`default_nettype none
module local_interrupt_prioritizer_test;
	logic clk = 0, reset = 1, poll = 0, t1 = 0, t2 = 0, sf_n = 1, af_n = 1, run = 0, tick = 0, ack, nmi, fs, fa;
	logic ce = 1, tick_p = 0, av;
	logic [7:1] lp;
	logic [6:1] sp;
	logic [13:0] qp[$], want_p;
	logic [7:1] src = 0, en = 0, edg = 0;
	logic [6:1] sreq = 0, sen = 0;
	logic [2:0] ipl, al, la, pl;
	logic [3:0] lag = 4'h2;
	logic [11:0] q[$], want;
	wire [11:0] got;
	int bad_count = 0, n_checks = 0;
	assign got = {nmi, ipl, pl, la, fs, fa};
	lip_top i_lip_top(.clk(clk), .reset(reset), .ce(ce), .test_switch(src[7]), .ptu1_req(src[6]),
		.ptu1_timer_req(t1), .ptu2_req(src[5]), .ptu2_timer_req(t2), .dual_serial_controller_req(src[4]),
		.multi_function_peripheral_req(src[3]), .network_req(src[2]), .disk_req(src[1]), .sysbus_irq(sreq),
		.sysfail_n(sf_n), .acfail_n(af_n), .local_enable(en), .local_edge(edg), .sys_enable(sen),
		.poll_mode(poll), .ack(ack), .ack_level(al), .cpu_ipl(ipl), .cpu_nmi(nmi), .local_pending(lp),
		.sys_pending(sp), .last_ack(la), .ack_valid(av), .poll_level(pl), .first_parallel_timer_unit_sysfail(fs),
		.first_parallel_timer_unit_acfail(fa));
	lip_cpu_model i_lip_cpu_model(.clk(clk), .reset(reset), .run(run), .lag(lag), .cpu_ipl(ipl), .ack(ack),
		.ack_level(al));
	initial forever #10 clk = ~clk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Note the expected status, then let the watcher compare it
	task automatic exp(input int n, input logic [11:0] e);
		repeat (n) @(posedge clk);
		q.push_back(e);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
	endtask
	task automatic exp_pend(input int n, input logic [13:0] e);
		repeat (n) @(posedge clk);
		qp.push_back(e);
		tick_p <= 1'b1;
		@(posedge clk);
		tick_p <= 1'b0;
	endtask
	task automatic chk(input string what, input logic [13:0] e, input logic [13:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic wack;
		int k;
		for (k = 0; k < 40 && ack !== 1'b1; k++) @(posedge clk);
		if (k == 40) begin
			bad_count++;
			print_verdict();
		end
	endtask
	// Watcher takes the oldest note when a result is due
	always @(posedge clk) begin
		if (tick) begin
			want = q.pop_front();
			chk("status", 14'(want), 14'(got));
		end
		if (tick_p) begin
			want_p = qp.pop_front();
			chk("pending", want_p, {lp, sp, av});
		end
	end
	initial begin
		void'($urandom(53));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		en <= 7'h7F;
		for (int i = 1; i < 7; i++) begin
			src <= 7'(1 << (i - 1)) | (7'($urandom) & 7'((1 << (i - 1)) - 1));
			exp(3, {1'b0, 3'(i), 3'(i), 5'h0});
		end
		en <= 7'h5F;
		src <= 7'h21;
		exp(3, {4'h1, 3'h1, 5'h0});
		en <= 7'h7F;
		src <= 7'h00;
		t1 <= 1'b1;
		exp(3, {4'h6, 3'h6, 5'h0});
		t1 <= 1'b0;
		t2 <= 1'b1;
		exp(3, {4'h5, 3'h5, 5'h0});
		$display("local levels done");
		t2 <= 1'b0;
		sen <= 6'h3F;
		sreq <= 6'h08;
		exp(3, {4'h4, 3'h4, 5'h0});
		exp_pend(0, {7'h00, 6'h08, 1'b0});
		poll <= 1'b1;
		exp(3, {4'h0, 3'h4, 5'h0});
		poll <= 1'b0;
		sen <= 6'h00;
		exp(3, {4'h0, 3'h0, 5'h0});
		$display("bus and poll done");
		sreq <= 6'h00;
		src <= 7'h40;
		exp(3, {4'hF, 3'h7, 5'h0});
		run <= 1'b1;
		wack();
		exp(4, {4'h0, 3'h0, 3'h7, 2'h0});
		exp_pend(0, {7'h00, 6'h00, 1'b1});
		lag <= 4'h5;
		edg <= 7'h02;
		src <= 7'h02;
		@(posedge clk);
		src <= 7'h00;
		exp(2, {4'h2, 3'h2, 3'h7, 2'h0});
		exp_pend(0, {7'h02, 6'h00, 1'b1});
		wack();
		exp(4, {4'h0, 3'h0, 3'h2, 2'h0});
		$display("acknowledge done");
		run <= 1'b0;
		ce <= 1'b0;
		src <= 7'h04;
		exp(3, {4'h0, 3'h0, 3'h2, 2'h0});
		ce <= 1'b1;
		exp(3, {4'h3, 3'h3, 3'h2, 2'h0});
		src <= 7'h00;
		$display("clock enable done");
		sf_n <= 1'b0;
		exp(3, {4'h0, 3'h0, 3'h2, 2'h2});
		af_n <= 1'b0;
		exp(3, {4'h0, 3'h0, 3'h2, 2'h3});
		$display("failure lines done");
		reset <= 1'b1;
		exp(2, 12'h000);
		exp_pend(0, 14'h0000);
		reset <= 1'b0;
		exp(3, {4'h0, 3'h0, 3'h0, 2'h3});
		$display("second reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
